// [bench/link_rx_model.sv]
// Purpose : Far-side link receiver: counts words, drives sync request.
// Assumes : Same clock as the generator.
// Notes   : Requests sync only early on, so it never disturbs a test.
`timescale 1ns/1ps
module link_rx_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [2:0]  link_test_mode,
	input  wire logic        sample_out_valid,
	input  wire logic        phy_out_valid,
	input  wire logic        scr_out_valid,
	output logic             link_sync_request_in,
	output logic [15:0]      rx_count
);
	// Count each cycle with a word on any lane; sync held off in link tests
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_count <= 16'h0000;
			link_sync_request_in <= 1'b1;
		end else begin
			rx_count <= rx_count + {15'h0000, sample_out_valid | phy_out_valid | scr_out_valid};
			link_sync_request_in <= link_test_mode == 3'h0 && rx_count < 16'h0010;
		end
	end
endmodule

// [bench/pattern_gen_checker.sv]
// Purpose : Port relations of the link test pattern generator.
// Assumes : Bound to jesd_link_test_pattern_gen; one clock domain.
// Notes   : Whole pattern sequences are judged by the bench, not here.
`timescale 1ns/1ps
module pattern_gen_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [3:0]  test_mode,
	input wire logic [1:0]  inject_point,
	input wire logic [2:0]  link_test_mode,
	input wire logic        link_sync_request_in,
	input wire logic [15:0] sample_in,
	input wire logic        sample_in_valid,
	input wire logic [9:0]  phy_in,
	input wire logic        phy_in_valid,
	input wire logic        scr_in_valid,
	input wire logic [15:0] sample_out,
	input wire logic        sample_out_valid,
	input wire logic [9:0]  phy_out,
	input wire logic        phy_out_valid,
	input wire logic [7:0]  scr_out,
	input wire logic        scr_out_valid,
	input wire logic        scr_out_is_k,
	input wire logic        link_sync_request_out,
	input wire logic        test_active
);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// No test of any kind selected
	wire idle = test_mode == 4'h0 && link_test_mode == 3'h0;
	chk_off_sample: assert property (
		idle && sample_in_valid |=> sample_out_valid && sample_out == $past(sample_in))
		else $error("sample data altered while off");
	chk_off_phy: assert property (
		idle && phy_in_valid |=> phy_out_valid && phy_out == $past(phy_in))
		else $error("phy data altered while off");
	chk_valid_delay: assert property (
		1'b1 |=> {sample_out_valid, phy_out_valid, scr_out_valid} ==
			$past({sample_in_valid, phy_in_valid, scr_in_valid}))
		else $error("output valid not one cycle after input valid");
	chk_flag_active: assert property (
		1'b1 |=> test_active == $past(!idle))
		else $error("test flag wrong");
	chk_sync_copy: assert property (
		1'b1 |=> link_sync_request_out == $past(link_sync_request_in))
		else $error("sync request not passed");
	// Generator patterns judged only once the mode has held an edge, as a change restarts them
	chk_checker_scr: assert property (
		test_mode == 4'h1 && inject_point == 2'h2 && link_test_mode == 3'h0 && scr_in_valid
		&& $stable(test_mode) && $stable(inject_point) |=> scr_out == 8'h55 || scr_out == 8'haa)
		else $error("octet checkerboard value wrong");
	chk_toggle_phy: assert property (
		test_mode == 4'h2 && inject_point == 2'h1 && phy_in_valid && $stable(test_mode)
		&& $stable(inject_point) |=> phy_out == 10'h000 || phy_out == 10'h3ff)
		else $error("symbol toggle value wrong");
	chk_user_octet: assert property (
		test_mode[3:1] == 3'h7 && inject_point == 2'h2 && link_test_mode == 3'h0
		&& scr_in_valid && $stable(test_mode) |=> scr_out_valid && !scr_out[7])
		else $error("user octet top bit set");
	chk_idle_char: assert property (
		link_test_mode == 3'h1 && test_mode == 4'h0 && inject_point == 2'h2 && scr_in_valid
		|=> scr_out == 8'hb5 && !scr_out_is_k)
		else $error("link data character wrong");
	chk_comma_char: assert property (
		link_test_mode == 3'h2 && test_mode == 4'h0 && inject_point == 2'h2 && scr_in_valid
		|=> scr_out == 8'hbc && scr_out_is_k)
		else $error("link control character wrong");
endmodule

bind jesd_link_test_pattern_gen pattern_gen_checker pattern_gen_checker_inst (.*);

// [bench/tb_top.sv]
// Purpose : Self-checking bench for the link test pattern generator.
// Assumes : Inputs change on falling edges; outputs one cycle after input.
// Notes   : Off-mode data differs from every pattern but the ramp, so leaks show.
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst, soft_reset, link_sync_request_in;
	logic [3:0]  test_mode;
	logic [1:0]  inject_point;
	logic [2:0]  link_test_mode;
	logic [15:0] user_pattern_word0, user_pattern_word1, user_pattern_word2, user_pattern_word3;
	logic [15:0] sample_in, sample_out, rx_count;
	logic [9:0]  phy_in, phy_out;
	logic [7:0]  scr_in, scr_out;
	logic        sample_in_valid, phy_in_valid, scr_in_valid, sample_out_valid, phy_out_valid;
	logic        scr_out_valid, scr_out_is_k, link_sync_request_out, test_active;
	logic [15:0] q[$];
	int          failures, n_compared, n_xfer;

	jesd_link_test_pattern_gen jesd_link_test_pattern_gen_inst (.*);
	link_rx_model link_rx_model_inst (.*);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One step at point pt; its output is looked at one cycle later
	task automatic xfer(input logic [1:0] pt, input logic [15:0] d, input logic [15:0] exp);
		sample_in_valid = pt == 2'h0;
		phy_in_valid = pt == 2'h1;
		scr_in_valid = pt == 2'h2;
		sample_in = d;
		phy_in = d[9:0];
		scr_in = d[7:0];
		@(negedge clk);
		n_xfer++;
		case (pt)
			2'h0: check({sample_out_valid, sample_out}, {1'b1, exp});
			2'h1: check({phy_out_valid, 6'h00, phy_out}, {1'b1, exp});
			default: check({scr_out_valid, 8'h00, scr_out}, {1'b1, exp});
		endcase
	endtask
	// New config with valid low for a cycle, which restarts the generator
	task automatic setup(input logic [3:0] m, input logic [1:0] pt, input logic [2:0] lm);
		sample_in_valid = 1'b0;
		phy_in_valid = 1'b0;
		scr_in_valid = 1'b0;
		test_mode = m;
		inject_point = pt;
		link_test_mode = lm;
		@(negedge clk);
	endtask
	// Sample point holds each word for a whole frame of four slots
	task automatic seq(input logic [3:0] m, input logic [1:0] pt);
		setup(m, pt, 3'h0);
		foreach (q[i])
			for (int r = 0; r < (pt == 2'h0 ? 4 : 1); r++)
				xfer(pt, 16'h9234, q[i]);
		q.delete();
		$display("Test done: mode %h point %h", m, pt);
	endtask
	function automatic logic [15:0] uw(input int i, input logic [1:0] pt);
		logic [15:0] w;
		w = i % 4 == 0 ? user_pattern_word0 : i % 4 == 1 ? user_pattern_word1 :
			i % 4 == 2 ? user_pattern_word2 : user_pattern_word3;
		return pt == 2'h0 ? w : pt == 2'h1 ? {6'h00, w[15:6]} : {9'h000, w[15:9]};
	endfunction

	// ------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		soft_reset = 1'b0;
		setup(4'h0, 2'h0, 3'h0);
		user_pattern_word0 = 16'h8123;
		user_pattern_word1 = 16'h4567;
		user_pattern_word2 = 16'hfe01;
		user_pattern_word3 = 16'h3a5c;
		repeat (5) @(negedge clk); // With the setup edge, six cycles of reset
		rst = 1'b0;
		for (int p = 0; p < 3; p++) begin
			setup(4'h0, p[1:0], 3'h0);
			xfer(p[1:0], 16'h9234, p == 0 ? 16'h9234 : p == 1 ? 16'h0234 : 16'h0034);
			check({15'h0000, test_active, link_sync_request_out}, 17'h00001);
		end
		$display("Test done: pass-through");
		q = '{16'h496f, 16'hc9a9, 16'h980c, 16'h651a, 16'h5fd1};
		seq(4'h6, 2'h0);
		q = '{16'hff5c, 16'h0029, 16'hb80a, 16'h3d72, 16'h9b26};
		seq(4'h4, 2'h0);
		q = '{16'h03fd, 16'h01c0, 16'h000a, 16'h01b8, 16'h0028};
		seq(4'h4, 2'h1);
		q = '{16'h0125, 16'h02fc, 16'h026a, 16'h0198, 16'h0031};
		seq(4'h6, 2'h1);
		q = '{16'h0049, 16'h006f, 16'h00c9, 16'h00a9, 16'h0098};
		seq(4'h6, 2'h2);
		q = '{16'h00ff, 16'h005c, 16'h0000, 16'h0029, 16'h00b8};
		seq(4'h4, 2'h2);
		q = '{16'h000e, 16'h0024, 16'h00da};
		seq(4'h7, 2'h2);
		q = '{16'h0007, 16'h005e, 16'h0013};
		seq(4'h5, 2'h2);
		q = '{16'h0000, 16'h0007, 16'h005f};
		seq(4'h3, 2'h2);
		for (int p = 0; p < 3; p++) begin
			for (int k = 0; k < 3; k++)
				q.push_back(k[0] ? 16'haaaa >> (p == 0 ? 0 : 2 * p + 4)
					: 16'h5555 >> (p == 0 ? 0 : 2 * p + 4));
			seq(4'h1, p[1:0]);
			for (int k = 0; k < 3; k++)
				q.push_back(k[0] ? 16'hffff >> (p == 0 ? 0 : 2 * p + 4) : 16'h0000);
			seq(4'h2, p[1:0]);
		end
		q = '{16'h0000, 16'h0001, 16'h0002};
		seq(4'h8, 2'h0);
		for (int p = 1; p < 3; p++) begin
			for (int k = 0; k < 1026; k++)
				q.push_back(p == 1 ? {6'h00, k[9:0]} : {8'h00, k[7:0]});
			seq(4'h8, p[1:0]);
		end
		for (int p = 0; p < 3; p++) begin
			for (int k = 0; k < 6; k++)
				q.push_back(uw(k, p[1:0]));
			seq(4'he, p[1:0]);
			for (int k = 0; k < 6; k++)
				q.push_back(k < 4 ? uw(k, p[1:0]) : 16'h0000);
			seq(4'hf, p[1:0]);
		end
		// Soft reset during a step: that step still uses the old state
		setup(4'h6, 2'h1, 3'h0);
		xfer(2'h1, 16'h9234, 16'h0125);
		soft_reset = 1'b1;
		xfer(2'h1, 16'h9234, 16'h02fc);
		soft_reset = 1'b0;
		xfer(2'h1, 16'h9234, 16'h0125);
		$display("Test done: soft restart");
		for (int m = 1; m < 4; m++) begin
			setup(4'h0, 2'h2, m[2:0]);
			xfer(2'h2, 16'h9234, m == 1 ? 16'h00b5 : m == 2 ? 16'h00bc : 16'h0034);
			check({15'h0000, test_active, scr_out_is_k}, {15'h0000, 1'b1, m == 2});
			check({16'h0000, link_sync_request_out}, 17'h00000);
		end
		$display("Test done: link layer modes");
		setup(4'h0, 2'h0, 3'h0);
		repeat (2) @(negedge clk);
		check({1'b0, rx_count}, {1'b0, n_xfer[15:0]});
		$display("Test done: word count");
		close_out();
	end
endmodule

// [hw/jesd_link_test_pattern_gen.v]
// Purpose : Test pattern injection for the converter's serial link datapath.
// Assumes : All inputs synchronous to clk; configuration held by a serial
//           control port outside this block and presented here as ports.
// Notes   : One shared generator serves whichever injection point is selected.
//           Sync request is passed through untouched; masking it during link
//           tests is left to the controller, as is the soft reset that restarts a
//           test. Injection point 3 sizes words like the sample point but
//           injects nowhere.
//
// Overview of operation
// - Point 00: 16-bit words at sample input, four slots per frame, step per frame
// - Point 01: 10-bit symbols at physical layer input, one step per symbol
// - Point 10: 8-bit octets ahead of scrambler, one step per octet
// - Checkerboard 0x5555/0xAAAA style and toggle zeros/ones, at injection width
// - Ramp adds one per step and wraps at injection width
// - PRBS order 9 sample words start 0x496F, 0xC9A9, 0x980C, 0x651A, 0x5FD1
// - PRBS order 23 sample words start 0xFF5C, 0x0029, 0xB80A, 0x3D72, 0x9B26
// - Physical layer symbols for both PRBS orders follow the same bitstream
// - Scrambler octets for both PRBS orders follow the same bitstream
// - User repeat cycles the four user words in order, forever
// - User words use bits 15:0, 15:6 or 15:9 depending on point
// - User single sends four user words once, then zeros
// - Three-bit field selects data link layer test modes
// - Link layer codes 1 and 2 send the standard's D21.5 and K28.5 characters
// - Configuration bytes are written and read through the serial control port
// - Four-bit field selects off, checker, toggle, PRBS orders, ramp, user modes
// - Four 16-bit user words come from eight configuration bytes
`timescale 1ns/1ps
`include "pattern_gen_map.vh"

module jesd_link_test_pattern_gen (
	input  wire        clk,
	input  wire        rst,
	input  wire [3:0]  test_mode,
	input  wire [1:0]  inject_point,
	input  wire [2:0]  link_test_mode,
	input  wire        soft_reset,
	input  wire [15:0] user_pattern_word0,
	input  wire [15:0] user_pattern_word1,
	input  wire [15:0] user_pattern_word2,
	input  wire [15:0] user_pattern_word3,
	input  wire        link_sync_request_in,
	input  wire [15:0] sample_in,
	input  wire        sample_in_valid,
	input  wire [9:0]  phy_in,
	input  wire        phy_in_valid,
	input  wire [7:0]  scr_in,
	input  wire        scr_in_valid,
	output reg  [15:0] sample_out,
	output reg         sample_out_valid,
	output reg  [9:0]  phy_out,
	output reg         phy_out_valid,
	output reg  [7:0]  scr_out,
	output reg         scr_out_valid,
	output reg         scr_out_is_k,
	output reg         link_sync_request_out,
	output reg         test_active
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Runs a Fibonacci LFSR n steps; the next stream bit is the MSB of the
	// order-wide state. Returns {word (right aligned), new state}.
	function [46:0] prbs_run;
		input [30:0] st;
		input [4:0]  ord;
		input [4:0]  tap;
		input [4:0]  n;
		reg   [30:0] s;
		reg   [15:0] w;
		reg          b;
		integer      i;
		begin
			s = st;
			w = `ZERO_WORD;
			for (i = 0; i < 16; i = i + 1) begin
				if (i < n) begin
					b = s[ord - 5'h01];
					w = {w[14:0], b};
					s = {s[29:0], b ^ s[tap - 5'h01]};
					s = s & ((31'h1 << ord) - 31'h1);
				end
			end
			prbs_run = {w, s};
		end
	endfunction

	// Order, tap and start state per selection code
	function [40:0] prbs_cfg;
		input [3:0] mode;
		begin
			case (mode)
				`TP_PRBS31: prbs_cfg = {`ORD31, `TAP31, `SEED31};
				`TP_PRBS23: prbs_cfg = {`ORD23, `TAP23, `SEED23};
				`TP_PRBS15: prbs_cfg = {`ORD15, `TAP15, `SEED15};
				`TP_PRBS7:  prbs_cfg = {`ORD7, `TAP7, `SEED7};
				default:    prbs_cfg = {`ORD9, `TAP9, `SEED9};
			endcase
		end
	endfunction

	// Decoded once per point; keeps the three output muxes in step
	function injecting;
		input [3:0] mode;
		input [1:0] pt;
		input [1:0] here;
		begin
			injecting = (mode != `TP_OFF) && (pt == here);
		end
	endfunction

	// ------------------------------------------------------------
	// Configuration decode
	// ------------------------------------------------------------
	reg  [3:0]  mode_q;
	reg  [1:0]  point_q;
	reg  [30:0] prbs_q;
	reg  [15:0] ramp_q;
	reg         phase_q;
	reg  [2:0]  user_idx_q;
	reg  [1:0]  slot_q;

	wire        gen_on    = (test_mode != `TP_OFF);
	wire        is_prbs   = (test_mode >= `TP_PRBS31) && (test_mode <= `TP_PRBS7);
	wire [40:0] pcfg      = prbs_cfg(test_mode);
	wire [4:0]  prbs_ord  = pcfg[40:36];
	wire [4:0]  prbs_tap  = pcfg[35:31];
	wire [30:0] prbs_seed = pcfg[30:0];
	// Any change of pattern or point, or a soft reset, restarts every generator
	wire        restart   = soft_reset || (test_mode != mode_q)
	                        || (inject_point != point_q);

	// Width and user alignment of the selected point
	// Sample steps once per frame of four slots; phy and scrambler points on every valid; point 3 never steps
	reg  [4:0]  width;
	reg  [3:0]  user_sh;
	reg         step;
	always @* begin
		case (inject_point)
			`PT_PHY: begin
				width   = `W_PHY;
				user_sh = `SH_PHY;
				step    = phy_in_valid;
			end
			`PT_SCRAMBLER: begin
				width   = `W_SCRAMBLER;
				user_sh = `SH_SCRAMBLER;
				step    = scr_in_valid;
			end
			default: begin
				width   = `W_SAMPLE;
				user_sh = `SH_SAMPLE;
				step    = sample_in_valid && (slot_q == `SLOTS_LAST);
			end
		endcase
	end

	// ------------------------------------------------------------
	// Pattern word
	// ------------------------------------------------------------
	wire [46:0] prbs_res = prbs_run(prbs_q, prbs_ord, prbs_tap, width);
	// A 16-bit point wraps the shift to zero, so bit 4 of the width forces ones
	wire [15:0] mask     = (16'h1 << width[3:0]) - 16'h1 | {16{width[4]}};

	// Selects the pattern word, then trims it to the point's width
	// User words are configuration byte pairs, held outside and seen as ports
	reg  [15:0] user_word;
	reg  [15:0] pat_raw;
	always @* begin
		case (user_idx_q[1:0])
			2'h0:    user_word = user_pattern_word0;
			2'h1:    user_word = user_pattern_word1;
			2'h2:    user_word = user_pattern_word2;
			default: user_word = user_pattern_word3;
		endcase
		case (test_mode)
			`TP_CHECKER:  pat_raw = phase_q ? `CHECK_B : `CHECK_A;
			`TP_TOGGLE:   pat_raw = phase_q ? `ALL_ONES : `ZERO_WORD;
			`TP_RAMP:     pat_raw = ramp_q;
			`TP_USER_REP: pat_raw = user_word >> user_sh;
			`TP_USER_ONE: pat_raw = user_idx_q[2] ? `ZERO_WORD
			                                       : (user_word >> user_sh);
			default:      pat_raw = is_prbs ? prbs_res[46:31] : `ZERO_WORD;
		endcase
	end
	wire [15:0] pat = pat_raw & mask;

	// ------------------------------------------------------------
	// Generator state
	// ------------------------------------------------------------

	// A restart wins over a step in the same cycle, so a fresh pattern always
	// begins at its first value; the word shown that cycle is the old state.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q     <= `TP_OFF;
			point_q    <= `PT_SAMPLE;
			prbs_q     <= `SEED9;
			ramp_q     <= `ZERO_WORD;
			phase_q    <= 1'b0;
			user_idx_q <= 3'h0;
			slot_q     <= 2'h0;
		end else begin
			mode_q  <= test_mode;
			point_q <= inject_point;
			if (restart) begin
				prbs_q     <= prbs_seed;
				ramp_q     <= `ZERO_WORD;
				phase_q    <= 1'b0;
				user_idx_q <= 3'h0;
				slot_q     <= 2'h0;
			end else begin
				if (inject_point == `PT_SAMPLE && sample_in_valid) begin
					slot_q <= slot_q + 2'h1;
				end
				if (gen_on && step) begin
					if (is_prbs) begin
						prbs_q <= prbs_res[30:0];
					end
					ramp_q  <= ramp_q + 16'h1;
					phase_q <= ~phase_q;
					if (test_mode == `TP_USER_REP) begin
						user_idx_q <= {1'b0, user_idx_q[1:0] + 2'h1};
					end else if (user_idx_q != `USER_DONE) begin
						user_idx_q <= user_idx_q + 3'h1;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Injection and link layer test output
	// ------------------------------------------------------------

	// Link layer characters replace the scrambler-input octet; modes that
	// need frame-level sequencing pass the octet stream through.
	// Codes 3 to 7 therefore raise the test flag and also block pattern injection at the scrambler point.
	reg  [7:0] link_octet;
	reg        link_k;
	reg        link_on;
	always @* begin
		case (link_test_mode)
			`LT_D21_5: begin
				link_octet = `CODE_D21_5;
				link_k     = 1'b0;
				link_on    = 1'b1;
			end
			`LT_K28_5: begin
				link_octet = `CODE_K28_5;
				link_k     = 1'b1;
				link_on    = 1'b1;
			end
			default: begin
				link_octet = scr_in;
				link_k     = 1'b0;
				link_on    = (link_test_mode != `LT_OFF);
			end
		endcase
	end

	// Point decode shared by the three output muxes; point 3 matches none
	wire        inj_sample = injecting(test_mode, inject_point, `PT_SAMPLE);
	wire        inj_phy    = injecting(test_mode, inject_point, `PT_PHY);
	wire        inj_scr    = injecting(test_mode, inject_point, `PT_SCRAMBLER);

	// Registered outputs, one cycle behind the inputs
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sample_out            <= `ZERO_WORD;
			sample_out_valid      <= 1'b0;
			phy_out               <= 10'h000;
			phy_out_valid         <= 1'b0;
			scr_out               <= 8'h00;
			scr_out_valid         <= 1'b0;
			scr_out_is_k          <= 1'b0;
			link_sync_request_out <= 1'b0;
			test_active           <= 1'b0;
		end else begin
			sample_out_valid <= sample_in_valid;
			phy_out_valid    <= phy_in_valid;
			scr_out_valid    <= scr_in_valid;
			sample_out <= inj_sample ? pat : sample_in;
			phy_out    <= inj_phy ? pat[9:0] : phy_in;
			if (link_on) begin
				scr_out      <= link_octet;
				scr_out_is_k <= link_k;
			end else begin
				scr_out      <= inj_scr ? pat[7:0] : scr_in;
				scr_out_is_k <= 1'b0;
			end
			// Controller must have masked sync request during link tests
			link_sync_request_out <= link_sync_request_in;
			test_active           <= gen_on || link_on;
		end
	end

endmodule

// [hw/pattern_gen_map.vh]
// Purpose : Named constants for the link test pattern generator.
// Assumes : Included by hw/jesd_link_test_pattern_gen.v only.
// Notes   : Stream starts for the two main PRBS orders are given as the first
//           stream bits, MSB first, so that the first word matches the tables.
`ifndef PATTERN_GEN_MAP_VH
`define PATTERN_GEN_MAP_VH

// ------------------------------------------------------------
// Pattern selection codes
// ------------------------------------------------------------
`define TP_OFF        4'h0
`define TP_CHECKER    4'h1
`define TP_TOGGLE     4'h2
`define TP_PRBS31     4'h3
`define TP_PRBS23     4'h4
`define TP_PRBS15     4'h5
`define TP_PRBS9      4'h6
`define TP_PRBS7      4'h7
`define TP_RAMP       4'h8
`define TP_USER_REP   4'he
`define TP_USER_ONE   4'hf

// ------------------------------------------------------------
// Injection points, widths and user word alignment
// ------------------------------------------------------------
`define PT_SAMPLE     2'h0
`define PT_PHY        2'h1
`define PT_SCRAMBLER  2'h2
`define W_SAMPLE      5'h10
`define W_PHY         5'h0a
`define W_SCRAMBLER   5'h08
`define SH_SAMPLE     4'h0
`define SH_PHY        4'h6
`define SH_SCRAMBLER  4'h9
`define SLOTS_LAST    2'h3

// ------------------------------------------------------------
// Fixed words
// ------------------------------------------------------------
`define CHECK_A       16'h5555
`define CHECK_B       16'haaaa
`define ALL_ONES      16'hffff
`define ZERO_WORD     16'h0000
`define USER_DONE     3'h4

// ------------------------------------------------------------
// PRBS orders, taps and starting states
// ------------------------------------------------------------
`define ORD31         5'h1f
`define TAP31         5'h1c
`define SEED31        31'h0003afff
`define ORD23         5'h17
`define TAP23         5'h12
`define SEED23        31'h007fae00
`define ORD15         5'h0f
`define TAP15         5'h0e
`define SEED15        31'h000003af
`define ORD9          5'h09
`define TAP9          5'h05
`define SEED9         31'h00000092
`define ORD7          5'h07
`define TAP7          5'h06
`define SEED7         31'h00000007

// ------------------------------------------------------------
// Data link layer test modes
// ------------------------------------------------------------
`define LT_OFF        3'h0
`define LT_D21_5      3'h1
`define LT_K28_5      3'h2
`define CODE_D21_5    8'hb5
`define CODE_K28_5    8'hbc

`endif
